// ---- common/bwm_pkg.sv ----
package bwm_pkg;

    // address space sizes
    localparam int          PHYS_REAL_BITS  = 20;
    localparam int          PHYS_PROT_BITS  = 24;
    localparam int          VIRT_PROT_BITS  = 30;
    localparam logic [24:0] PHYS_REAL_SIZE  = 25'h0100000;
    localparam logic [24:0] PHYS_PROT_SIZE  = 25'h1000000;
    localparam logic [16:0] SEG_MAX_LEN     = 17'h10000;
    localparam logic [16:0] STR_MAX_LEN     = 17'h10000;
    localparam logic [13:0] SEG_COUNT_MAX   = 14'h3FFF;

    // byte and word layout
    localparam int          BYTE_MSB        = 7;
    localparam int          WORD_MSB        = 15;
    localparam int          LOW_BYTE_POS    = 0;
    localparam int          HIGH_BYTE_POS   = 8;
    localparam logic [3:0]  BCD_DIGIT_MAX   = 4'h9;

    // reset values
    localparam logic [15:0] RST_DATA        = 16'h0000;
    localparam logic [23:0] RST_ADDR        = 24'h000000;

    typedef enum logic [1:0] {
        BWM_OP_BYTE,
        BWM_OP_WORD,
        BWM_OP_FETCH
    } bwm_op_type;

    typedef enum logic [2:0] {
        BWM_DT_ORDINAL,
        BWM_DT_INTEGER,
        BWM_DT_UNPACKED_BCD,
        BWM_DT_PACKED_BCD,
        BWM_DT_POINTER_OFS,
        BWM_DT_POINTER_SEL
    } bwm_dtype_type;

    // request from the execution unit
    typedef struct packed {
        logic          write;
        bwm_op_type    op;
        bwm_dtype_type dtype;
        logic          mapped;
        logic [29:0]   addr;
        logic [15:0]   wdata;
    } bwm_req_type;

    // one aligned word cycle on the memory interface
    typedef struct packed {
        logic          write;
        logic [22:0]   word_addr;
        logic [1:0]    byte_en;
        logic [15:0]   wdata;
    } bwm_mem_type;

    // completed answer back to the execution unit
    typedef struct packed {
        logic [15:0]   rdata;
        logic          negative;
        logic          bcd_valid;
        logic          range_err;
        logic [31:0]   pointer;
    } bwm_rsp_type;

endpackage

// ---- rtl/bwm_access.sv ----
`timescale 1ns/1ps
module bwm_access (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    // execution unit request
    input  wire logic                 req_valid,
    output logic                      req_ready,
    input  wire bwm_pkg::bwm_req_type req,
    input  wire logic [23:0]          xlat_base,
    input  wire logic [16:0]          seg_limit,
    input  wire logic [16:0]          str_len,
    // execution unit answer
    output logic                      rsp_valid,
    output bwm_pkg::bwm_rsp_type      rsp,
    // memory interface
    output logic                      mem_valid,
    input  wire logic                 mem_ready,
    output bwm_pkg::bwm_mem_type      mem,
    input  wire logic                 mem_rvalid,
    input  wire logic [15:0]          mem_rdata
);

    typedef enum logic [2:0] {
        BWM_IDLE,
        BWM_FIRST,
        BWM_FIRST_WAIT,
        BWM_SECOND,
        BWM_SECOND_WAIT,
        BWM_DONE
    } bwm_state_type;

    bwm_state_type          state;
    bwm_state_type          next_state;
    bwm_pkg::bwm_req_type   cur;
    bwm_pkg::bwm_req_type   next_cur;
    logic [23:0]            phys;
    logic [23:0]            next_phys;
    logic [15:0]            data;
    logic [15:0]            next_data;
    logic [15:0]            sel;
    logic [15:0]            next_sel;
    logic                   err;
    logic                   next_err;
    logic                   split;
    logic [23:0]            phys_calc;
    logic                   oob;
    logic [7:0]             lane_byte;
    logic                   pend;
    logic                   next_pend;
    logic                   done_o;
    logic                   next_done_o;

    // address formation: unmapped passes the low 20 bits straight through, mapped adds
    // the segment base; translation itself lives outside, only its base arrives here
    always_comb begin
        phys_calc = bwm_pkg::RST_ADDR;
        if (req.mapped) begin
            phys_calc = xlat_base + {8'h00, req.addr[15:0]};
        end else begin
            phys_calc = {4'h0, req.addr[19:0]};
        end
    end

    // offset past the segment end, or a string length of zero or above STR_MAX_LEN, is flagged, not faulted on
    // alignment; a word needs both bytes inside the limit
    always_comb begin
        oob = 1'b0;
        if (req.mapped) begin
            oob = ({1'b0, req.addr[15:0]} + ((req.op == bwm_pkg::BWM_OP_WORD) ? 17'h00001 : 17'h00000))
                  >= seg_limit;
        end
        if (str_len == 17'h00000 || str_len > bwm_pkg::STR_MAX_LEN) begin
            oob = 1'b1;
        end
        // every 14-bit selector names a supported segment, so this stays quiet for legal requests
        if (req.mapped && req.addr[29:16] > bwm_pkg::SEG_COUNT_MAX) begin
            oob = 1'b1;
        end
    end

    // a word starting on an odd byte needs two aligned cycles; fetches never split
    // because the prefetch queue absorbs byte alignment
    assign split = (cur.op == bwm_pkg::BWM_OP_WORD) && phys[0];

    // pick the addressed lane of an aligned word: even address is bits 7:0
    assign lane_byte = phys[0] ? mem_rdata[15:8] : mem_rdata[7:0];

    // sequencing of aligned memory cycles
    always_comb begin
        next_state  = state;
        next_cur    = cur;
        next_phys   = phys;
        next_data   = data;
        next_sel    = sel;
        next_err    = err;
        next_pend   = pend;
        next_done_o = 1'b0;
        unique case (state)
            BWM_IDLE: begin
                if (req_valid) begin
                    next_cur   = req;
                    next_phys  = phys_calc;
                    next_err   = oob;
                    next_data  = bwm_pkg::RST_DATA;
                    if (req.dtype == bwm_pkg::BWM_DT_POINTER_SEL) begin
                        next_sel = req.wdata; // selector half of a pointer held here
                    end
                    next_state = BWM_FIRST;
                end
            end
            BWM_FIRST: begin
                if (mem_ready) begin
                    next_state = cur.write ? (split ? BWM_SECOND : BWM_DONE) : BWM_FIRST_WAIT;
                end
            end
            BWM_FIRST_WAIT: begin
                if (mem_rvalid) begin
                    if (cur.op == bwm_pkg::BWM_OP_BYTE) begin
                        next_data  = {8'h00, lane_byte};
                        next_state = BWM_DONE;
                    end else if (split) begin
                        next_data  = {8'h00, mem_rdata[15:8]};
                        next_state = BWM_SECOND;
                    end else begin
                        next_data  = mem_rdata;
                        next_state = BWM_DONE;
                    end
                end
            end
            BWM_SECOND: begin
                if (mem_ready) begin
                    next_state = cur.write ? BWM_DONE : BWM_SECOND_WAIT;
                end
            end
            BWM_SECOND_WAIT: begin
                if (mem_rvalid) begin
                    next_data  = {mem_rdata[7:0], data[7:0]};
                    next_state = BWM_DONE;
                end
            end
            BWM_DONE: begin
                next_done_o = 1'b1;
                next_state  = BWM_IDLE;
            end
        endcase
        next_pend = (next_state == BWM_FIRST) || (next_state == BWM_SECOND);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state  <= BWM_IDLE;
            cur    <= '0;
            phys   <= bwm_pkg::RST_ADDR;
            data   <= bwm_pkg::RST_DATA;
            sel    <= bwm_pkg::RST_DATA;
            err    <= 1'b0;
            pend   <= 1'b0;
            done_o <= 1'b0;
        end else begin
            state  <= next_state;
            cur    <= next_cur;
            phys   <= next_phys;
            data   <= next_data;
            sel    <= next_sel;
            err    <= next_err;
            pend   <= next_pend;
            done_o <= next_done_o;
        end
    end

    // memory cycle: word address drops bit 0 so every transfer is aligned; the second
    // half of a split goes to the next word with only its low lane enabled
    always_comb begin
        mem           = '0;
        mem.write     = cur.write;
        mem.word_addr = phys[23:1];
        if (state == BWM_SECOND) begin
            mem.word_addr = phys[23:1] + 23'h000001;
            mem.byte_en   = 2'b01;
            mem.wdata     = {8'h00, cur.wdata[15:8]}; // high byte at higher address
        end else if (cur.op == bwm_pkg::BWM_OP_BYTE || split) begin
            mem.byte_en   = phys[0] ? 2'b10 : 2'b01;
            mem.wdata     = phys[0] ? {cur.wdata[7:0], 8'h00} : {8'h00, cur.wdata[7:0]};
        end else begin
            mem.byte_en   = 2'b11;
            mem.wdata     = cur.wdata; // low byte at the word address
        end
    end

    assign mem_valid = pend;
    assign req_ready = (state == BWM_IDLE);
    assign rsp_valid = done_o;

    // operand interpretation of the assembled value
    always_comb begin
        rsp           = '0;
        rsp.rdata     = data;
        rsp.range_err = err;
        rsp.pointer   = {sel, data}; // selector in 31:16, offset in 15:0
        unique case (cur.dtype)
            bwm_pkg::BWM_DT_INTEGER: begin
                rsp.negative = (cur.op == bwm_pkg::BWM_OP_BYTE) ? data[bwm_pkg::BYTE_MSB]
                                                                : data[bwm_pkg::WORD_MSB];
            end
            bwm_pkg::BWM_DT_UNPACKED_BCD: begin
                rsp.bcd_valid = (data[3:0] <= bwm_pkg::BCD_DIGIT_MAX);
            end
            bwm_pkg::BWM_DT_PACKED_BCD: begin
                rsp.bcd_valid = (data[3:0] <= bwm_pkg::BCD_DIGIT_MAX)
                              && (data[7:4] <= bwm_pkg::BCD_DIGIT_MAX);
            end
            default: begin
                rsp.negative = 1'b0; // ordinals and pointers are unsigned
            end
        endcase
    end

endmodule

// ---- tb/bwm_access_properties.sv ----
`timescale 1ns/1ps
module bwm_chk (
    // clock and reset
    input wire logic                 ref_clk,
    input wire logic                 rst,
    // request side
    input wire logic                 req_valid,
    input wire logic                 req_ready,
    input wire bwm_pkg::bwm_req_type req,
    input wire logic                 rsp_valid,
    // memory side
    input wire logic                 mem_valid,
    input wire logic                 mem_ready,
    input wire bwm_pkg::bwm_mem_type mem
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic go;
    // unmapped word request taken this edge
    assign go = req_valid && req_ready && !req.mapped && req.op == bwm_pkg::BWM_OP_WORD;
    mem_hold_a: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem))
        else $error("memory cycle changed before accept");
    odd_split_a: assert property (go && req.addr[0] |=> mem_valid && mem.byte_en == 2'b10
        && mem.word_addr == $past(req.addr[19:1])) else $error("odd word first cycle wrong");
    even_word_a: assert property (go && !req.addr[0] |=> mem_valid && mem.byte_en == 2'b11
        && mem.word_addr == $past(req.addr[19:1])) else $error("even word cycle wrong");
    split_data_a: assert property (go && req.write && req.addr[0] |=> mem.write
        && mem.wdata[15:8] == $past(req.wdata[7:0])) else $error("odd write lane wrong");
    lane_used_a: assert property (mem_valid |-> mem.byte_en != 2'b00)
        else $error("memory cycle with no byte lane");
    busy_ready_a: assert property (mem_valid |-> !req_ready)
        else $error("request accepted while busy");
    done_in_a: assert property (req_valid && req_ready |-> ##[2:60] rsp_valid)
        else $error("request never completed");
    rsp_pulse_a: assert property (rsp_valid |-> req_ready ##1 !rsp_valid)
        else $error("answer pulse wrong");
    // main scenarios reached
    cover property (go && req.addr[0]);
    cover property (mem_valid && !mem_ready);
    cover property (req_valid && req_ready && req.op == bwm_pkg::BWM_OP_FETCH);
    cover property (req_valid && req_ready && req.mapped);
endmodule
bind bwm_access bwm_chk chk (.ref_clk, .rst, .req_valid, .req_ready, .req, .rsp_valid, .mem_valid, .mem_ready, .mem);

// ---- tb/bwm_mem_model.sv ----
`timescale 1ns/1ps
module bwm_mem_model (
    // clock and reset
    input wire logic                 ref_clk,
    input wire logic                 rst,
    input wire logic                 slow,
    // memory interface
    input wire logic                 mem_valid,
    output logic                     mem_ready,
    input wire bwm_pkg::bwm_mem_type mem,
    output logic                     mem_rvalid,
    output logic [15:0]              mem_rdata
);
    logic [15:0] m [0:255];
    logic        hold;
    // slow mode accepts only every other cycle
    assign mem_ready = mem_valid && !(slow && hold);
    // lane 0 is the even byte; data toggles outside returns so stale values never match
    always @(posedge ref_clk) begin
        hold <= rst ? 1'b1 : !hold;
        mem_rvalid <= !rst && mem_ready && !mem.write;
        mem_rdata <= rst ? 16'h0000 : (mem_ready && !mem.write) ? m[mem.word_addr[7:0]] : ~mem_rdata;
        if (!rst && mem_ready && mem.write && mem.byte_en[0]) m[mem.word_addr[7:0]][7:0] <= mem.wdata[7:0];
        if (!rst && mem_ready && mem.write && mem.byte_en[1]) m[mem.word_addr[7:0]][15:8] <= mem.wdata[15:8];
    end
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    logic                 ref_clk = 1'b0;
    logic                 rst = 1'b1;
    logic                 req_valid = 1'b0;
    logic                 slow = 1'b0;
    logic                 req_ready, rsp_valid, mem_valid, mem_ready, mem_rvalid;
    logic [23:0]          xlat_base = 24'h000000;
    logic [16:0]          seg_limit = 17'h10000;
    logic [16:0]          str_len = 17'h00001;
    logic [15:0]          mem_rdata;
    bwm_pkg::bwm_req_type req = '0;
    bwm_pkg::bwm_rsp_type rsp;
    bwm_pkg::bwm_mem_type mem, first;
    int                   fail_count = 0;
    int                   checks = 0;
    int                   beats;
    bwm_access uut (.ref_clk, .rst, .req_valid, .req_ready, .req, .xlat_base, .seg_limit, .str_len,
        .rsp_valid, .rsp, .mem_valid, .mem_ready, .mem, .mem_rvalid, .mem_rdata);
    bwm_mem_model ram (.ref_clk, .rst, .slow, .mem_valid, .mem_ready, .mem, .mem_rvalid, .mem_rdata);
    // 20 MHz clock
    always #25 ref_clk = ~ref_clk;
    task automatic stop_test;
        if (fail_count == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask
    // one request, held for one rising edge only, without waiting on ready; handshakes are counted at the falling
    // edge, where the model's combinational ready has settled, then the bench realigns to the
    // rising edge at which the answer pulse ends, so the next request starts there
    task automatic run(input logic w, input bwm_pkg::bwm_op_type op, input bwm_pkg::bwm_dtype_type dt,
                       input logic mp, input logic [29:0] a, input logic [15:0] d);
        int n;
        req <= '{w, op, dt, mp, a, d};
        req_valid <= 1'b1;
        @(posedge ref_clk);
        req_valid <= 1'b0;
        beats = 0;
        for (n = 0; n < 60; n++) begin
            @(negedge ref_clk);
            if (mem_valid && mem_ready) begin
                if (beats == 0) first = mem;
                beats++;
            end
            if (rsp_valid) break;
        end
        @(posedge ref_clk);
        if (n == 60) begin
            fail_count++;
            stop_test();
        end
    endtask
    task automatic t_words;
        run(1, bwm_pkg::BWM_OP_WORD, bwm_pkg::BWM_DT_ORDINAL, 0, 30'h200, 16'hBEEF);
        chk("beats", 1, beats);
        chk("lanes", 2'b11, first.byte_en);
        chk("word_addr", 23'h100, first.word_addr);
        run(1, bwm_pkg::BWM_OP_WORD, bwm_pkg::BWM_DT_ORDINAL, 0, 30'h201, 16'h1234);
        chk("split beats", 2, beats);
        chk("first lanes", 2'b10, first.byte_en);
        chk("first data", 8'h34, first.wdata[15:8]);
        run(0, bwm_pkg::BWM_OP_WORD, bwm_pkg::BWM_DT_INTEGER, 0, 30'h201, 16'h0000);
        chk("odd read", 16'h1234, rsp.rdata);
        chk("odd read beats", 2, beats);
        chk("sign", 0, rsp.negative);
        slow <= 1'b1;
        run(0, bwm_pkg::BWM_OP_WORD, bwm_pkg::BWM_DT_ORDINAL, 0, 30'h200, 16'h0000);
        chk("merged word", 16'h34EF, rsp.rdata);
        slow <= 1'b0;
        // bits above the one megabyte range are dropped in the unmapped mode
        run(0, bwm_pkg::BWM_OP_WORD, bwm_pkg::BWM_DT_ORDINAL, 0, 30'h3FF00200, 16'h0000);
        chk("unmapped wrap addr", 23'h100, first.word_addr);
        chk("unmapped wrap word", 16'h34EF, rsp.rdata);
        run(0, bwm_pkg::BWM_OP_FETCH, bwm_pkg::BWM_DT_ORDINAL, 0, 30'h201, 16'h0000);
        chk("fetch beats", 1, beats);
        chk("fetch word", 16'h34EF, rsp.rdata);
    endtask
    task automatic t_types;
        run(0, bwm_pkg::BWM_OP_BYTE, bwm_pkg::BWM_DT_INTEGER, 0, 30'h200, 16'h0000);
        chk("low byte", 8'hEF, rsp.rdata[7:0]);
        chk("int sign", 1, rsp.negative);
        run(0, bwm_pkg::BWM_OP_BYTE, bwm_pkg::BWM_DT_ORDINAL, 0, 30'h200, 16'h0000);
        chk("ordinal sign", 0, rsp.negative);
        run(0, bwm_pkg::BWM_OP_BYTE, bwm_pkg::BWM_DT_PACKED_BCD, 0, 30'h200, 16'h0000);
        chk("bad bcd", 0, rsp.bcd_valid);
        run(0, bwm_pkg::BWM_OP_BYTE, bwm_pkg::BWM_DT_UNPACKED_BCD, 0, 30'h200, 16'h0000);
        chk("bad unpacked", 0, rsp.bcd_valid);
        run(1, bwm_pkg::BWM_OP_WORD, bwm_pkg::BWM_DT_ORDINAL, 0, 30'h204, 16'h0998);
        run(0, bwm_pkg::BWM_OP_BYTE, bwm_pkg::BWM_DT_PACKED_BCD, 0, 30'h204, 16'h0000);
        chk("good bcd", 1, rsp.bcd_valid);
        run(0, bwm_pkg::BWM_OP_BYTE, bwm_pkg::BWM_DT_UNPACKED_BCD, 0, 30'h204, 16'h0000);
        chk("good unpacked", 1, rsp.bcd_valid);
        run(0, bwm_pkg::BWM_OP_WORD, bwm_pkg::BWM_DT_POINTER_SEL, 0, 30'h200, 16'h0ABC);
        run(0, bwm_pkg::BWM_OP_WORD, bwm_pkg::BWM_DT_POINTER_OFS, 0, 30'h204, 16'h0000);
        chk("pointer", 32'h0ABC0998, rsp.pointer);
    endtask
    task automatic t_mapped;
        logic [16:0] len [3] = '{17'h00000, 17'h10000, 17'h10001};
        xlat_base <= 24'h000100;
        run(0, bwm_pkg::BWM_OP_BYTE, bwm_pkg::BWM_DT_ORDINAL, 1, 30'h0000104, 16'h0000);
        chk("mapped addr", 23'h102, first.word_addr);
        chk("mapped byte", 8'h98, rsp.rdata[7:0]);
        // highest selector is still a supported segment
        run(0, bwm_pkg::BWM_OP_BYTE, bwm_pkg::BWM_DT_ORDINAL, 1, 30'h3FFF0104, 16'h0000);
        chk("top selector", 0, rsp.range_err);
        // segment end: last byte inside, a word reaching one byte past it is flagged but still read
        seg_limit <= 17'h00105;
        run(0, bwm_pkg::BWM_OP_BYTE, bwm_pkg::BWM_DT_ORDINAL, 1, 30'h0000104, 16'h0000);
        chk("last segment byte", 0, rsp.range_err);
        run(0, bwm_pkg::BWM_OP_WORD, bwm_pkg::BWM_DT_ORDINAL, 1, 30'h0000104, 16'h0000);
        chk("word past segment", 1, rsp.range_err);
        chk("flagged word", 16'h0998, rsp.rdata);
        seg_limit <= 17'h10000;
        for (int i = 0; i < 3; i++) begin
            str_len <= len[i];
            run(0, bwm_pkg::BWM_OP_BYTE, bwm_pkg::BWM_DT_ORDINAL, 0, 30'h204, 16'h0000);
            chk("range_err", i != 1, rsp.range_err);
        end
    endtask
    // reset for 20 cycles, then the scenarios
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        t_words();
        t_types();
        t_mapped();
        stop_test();
    end
endmodule
